/* File: halt_standby_control.sv */
// halt standby controller: halt entry, clock gating, wake and warm-up
// assumes a cpu halt pulse, interrupt controller request and two async pins
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ns

module halt_standby_control
  import halt_standby_pkg::*;
#(
  parameter int unsigned WARMUP_BASE_CYC = 256
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_halt_exec,
  input  wire logic [2:0] i_mask_level,
  input  irq_req_t        i_irq,
  input  wire logic       i_nmi_pin,
  input  wire logic       i_primary_external_irq_pin,
  input  wire logic [2:0] i_primary_external_irq_level,
  input  wire logic [7:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [31:0]     o_rdata,
  output gate_t           o_gate,
  output logic            o_clk_out,
  output logic            o_service,
  output src_t            o_service_src,
  output logic            o_resume,
  output logic            o_ram_retain
);

  localparam int unsigned PINS = 2;

  // pin synchronisers, change accepted when stages two and three agree
  logic [PINS-1:0] pin_raw;
  logic [PINS-1:0] sync1_q;
  logic [PINS-1:0] sync2_q;
  logic [PINS-1:0] sync3_q;
  logic [PINS-1:0] pin_q;
  logic [PINS-1:0] pin_d;
  logic [PINS-1:0] pin_rise;

  assign pin_raw = {i_primary_external_irq_pin, i_nmi_pin};

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_sync
      always_comb begin
        pin_d[g] = (sync2_q[g] == sync3_q[g]) ? sync3_q[g] : pin_q[g];
      end
      always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
          pin_q[g]   <= 1'b0;
        end else begin
          sync1_q[g] <= pin_raw[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          pin_q[g]   <= pin_d[g];
        end
      end
      assign pin_rise[g] = pin_d[g] & ~pin_q[g];
    end
  endgenerate

  logic nmi_ev;
  logic primary_external_irq_req;
  logic nmi_seen_q;
  logic nmi_seen_d;
  assign nmi_ev   = pin_rise[0] | nmi_seen_q;
  assign primary_external_irq_req = pin_q[1];

  // wake decision for one source class in one halt state
  function automatic logic [1:0] wake_eval(input state_t st, input src_t src,
                                           input logic above, input logic wd_ad);
    logic wake;
    logic serve;
    wake  = 1'b0;
    serve = 1'b0;
    unique case (src)
      SRC_NMI: begin
        wake  = 1'b1;
        serve = 1'b1;
      end
      SRC_PRIMARY_EXTERNAL_IRQ: begin
        wake  = 1'b1;
        serve = above;
      end
      SRC_OTHER: begin
        if (st == ST_H_RUN) begin
          wake = above;
        end else if (st == ST_H_PERIPH) begin
          wake = above & ~wd_ad;
        end else begin
          wake = 1'b0;
        end
        serve = wake;
      end
      SRC_NONE: begin
        wake  = 1'b0;
        serve = 1'b0;
      end
    endcase
    return {wake, serve};
  endfunction

  // register port: control word and status
  logic [3:0]  ctrl_q;
  logic [3:0]  ctrl_d;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  // state machine group
  state_t      state_q;
  state_t      state_d;
  logic [1:0]  mode_q;
  logic [1:0]  mode_d;
  logic [1:0]  enter_cnt_q;
  logic [1:0]  enter_cnt_d;
  logic [19:0] warm_cnt_q;
  logic [19:0] warm_cnt_d;
  logic        pend_nmi_q;
  logic        pend_nmi_d;
  logic        pend_i0_q;
  logic        pend_i0_d;
  logic        serve_q;
  logic        serve_d;
  src_t        src_q;
  src_t        src_d;
  logic        clk_q;
  logic        clk_d;
  gate_t       gate_q;
  gate_t       gate_d;
  logic        service_q;
  logic        service_d;
  logic        resume_q;
  logic        resume_d;
  src_t        osrc_q;
  src_t        osrc_d;

  logic [19:0] warm_target;
  logic        fall_en;
  logic        sample_en;
  logic        i0_above;
  logic        oth_above;
  logic [1:0]  ev_nmi;
  logic [1:0]  ev_i0;
  logic [1:0]  ev_oth;

  assign warm_target = 20'(WARMUP_BASE_CYC) << {ctrl_q[CTRL_WARM_LSB+1:CTRL_WARM_LSB], 1'b0};
  assign fall_en     = clk_q & gate_q.sysclk_en;
  assign i0_above    = (i_primary_external_irq_level >= i_mask_level);
  assign oth_above   = i_irq.valid & (i_irq.level >= i_mask_level);
  assign ev_nmi      = wake_eval(state_q, nmi_ev ? SRC_NMI : SRC_NONE, 1'b1, 1'b0);
  assign ev_i0       = wake_eval(state_q, primary_external_irq_req ? SRC_PRIMARY_EXTERNAL_IRQ : SRC_NONE, i0_above, 1'b0);
  assign ev_oth      = wake_eval(state_q, i_irq.valid ? SRC_OTHER : SRC_NONE,
                                 oth_above, i_irq.wd_or_conv);

  // an nmi edge between two falling clock-out edges waits for the next one
  always_comb begin
    nmi_seen_d = (pin_rise[0] | nmi_seen_q) & (state_q == ST_H_RUN) & ~fall_en;
  end

  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = 32'h0;
    if (i_wr && i_addr == ADDR_CTRL) begin
      ctrl_d = i_wdata[3:0];
    end
    if (i_rd) begin
      unique case (i_addr)
        ADDR_CTRL: begin
          rdata_d[3:0] = ctrl_q;
        end
        ADDR_STATUS: begin
          rdata_d[7:0]         = state_q;
          rdata_d[STAT_PEND_NMI] = pend_nmi_q;
          rdata_d[STAT_PEND_I0]  = pend_i0_q;
        end
        default: begin
          rdata_d = 32'h0;
        end
      endcase
    end
  end

  always_comb begin
    state_d     = state_q;
    mode_d      = mode_q;
    enter_cnt_d = enter_cnt_q;
    warm_cnt_d  = warm_cnt_q;
    pend_nmi_d  = pend_nmi_q;
    pend_i0_d   = pend_i0_q;
    serve_d     = serve_q;
    src_d       = src_q;
    service_d   = 1'b0;
    resume_d    = 1'b0;
    osrc_d      = SRC_NONE;
    sample_en   = 1'b0;
    unique case (state_q)
      ST_ACTIVE: begin
        if (i_halt_exec) begin
          mode_d = ctrl_q[CTRL_MODE_LSB+1:CTRL_MODE_LSB];
          unique case (mode_d)
            MODE_RUN:   state_d = ST_H_RUN;
            MODE_IDLE_PERIPHERAL_MODE: state_d = ST_H_PERIPH;
            default: begin
              state_d     = ST_ENTER;
              enter_cnt_d = 2'h0;
            end
          endcase
        end
      end
      ST_ENTER: begin
        // pin requests here are held, not acted on
        pend_nmi_d  = pend_nmi_q | nmi_ev;
        pend_i0_d   = pend_i0_q | primary_external_irq_req;
        enter_cnt_d = enter_cnt_q + 2'h1;
        if (enter_cnt_q == 2'(ENTRY_OSC_CLOCKS - 1)) begin
          state_d = (mode_q == MODE_STOP) ? ST_H_STOP : ST_H_OSC;
        end
      end
      ST_H_RUN, ST_H_PERIPH, ST_H_OSC, ST_H_STOP: begin
        sample_en = (state_q == ST_H_RUN) ? fall_en : 1'b1;
        if (sample_en && (ev_nmi[1] || ev_i0[1] || ev_oth[1])) begin
          // highest priority among new and held requests
          if (ev_nmi[1] || pend_nmi_q) begin
            src_d     = SRC_NMI;
            serve_d   = 1'b1;
            pend_i0_d = pend_i0_q | ev_i0[1];
          end else if (ev_i0[1] || pend_i0_q) begin
            src_d   = SRC_PRIMARY_EXTERNAL_IRQ;
            serve_d = ev_i0[1] ? ev_i0[0] : i0_above;
          end else begin
            src_d   = SRC_OTHER;
            serve_d = ev_oth[0];
          end
          if (state_q == ST_H_STOP) begin
            state_d    = ST_WARMUP;
            warm_cnt_d = 20'h0;
          end else begin
            state_d = ST_WAKE;
          end
        end
      end
      ST_WARMUP: begin
        warm_cnt_d = warm_cnt_q + 20'h1;
        if (warm_cnt_q >= warm_target - 20'h1) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        service_d = serve_q;
        resume_d  = ~serve_q;
        osrc_d    = src_q;
        if (src_q == SRC_NMI) begin
          pend_nmi_d = 1'b0;
          serve_d    = pend_i0_q & i0_above;
          src_d      = pend_i0_q ? SRC_PRIMARY_EXTERNAL_IRQ : SRC_NONE;
        end else begin
          pend_i0_d = 1'b0;
          serve_d   = pend_nmi_q;
          src_d     = pend_nmi_q ? SRC_NMI : SRC_NONE;
        end
        // a still-held request is handed on after the first one
        state_d = (src_d == SRC_NONE) ? ST_ACTIVE : ST_WAKE;
      end
    endcase
  end

  // gating follows the next state so outputs come straight from flops
  always_comb begin
    gate_d = '{cpu_run: 1'b0, sysclk_en: 1'b1, periph_all_en: 1'b1,
               periph_subset_en: 1'b1, osc_en: 1'b1};
    clk_d  = ~clk_q;
    unique case (state_d)
      ST_ACTIVE, ST_WAKE: begin
        gate_d.cpu_run = 1'b1;
      end
      ST_H_RUN: begin
        gate_d.cpu_run = 1'b0;
      end
      ST_H_PERIPH, ST_ENTER: begin
        gate_d.periph_all_en = 1'b0;
      end
      ST_H_OSC: begin
        gate_d = '{cpu_run: 1'b0, sysclk_en: 1'b0, periph_all_en: 1'b0,
                   periph_subset_en: 1'b0, osc_en: 1'b1};
        clk_d  = 1'b1;
      end
      ST_H_STOP: begin
        gate_d = '{cpu_run: 1'b0, sysclk_en: 1'b0, periph_all_en: 1'b0,
                   periph_subset_en: 1'b0, osc_en: 1'b0};
        clk_d  = 1'b1;
      end
      ST_WARMUP: begin
        gate_d = '{cpu_run: 1'b0, sysclk_en: 1'b0, periph_all_en: 1'b0,
                   periph_subset_en: 1'b0, osc_en: 1'b1};
        clk_d  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      // reset releases any halt at once; RESET_STOP_MIN_CYC is only used by the bench
      state_q     <= ST_ACTIVE;
      mode_q      <= MODE_RUN;
      ctrl_q      <= CTRL_RESET;
      rdata_q     <= 32'h0;
      enter_cnt_q <= 2'h0;
      warm_cnt_q  <= 20'h0;
      pend_nmi_q  <= 1'b0;
      pend_i0_q   <= 1'b0;
      serve_q     <= 1'b0;
      src_q       <= SRC_NONE;
      clk_q       <= 1'b1;
      gate_q      <= '{cpu_run: 1'b1, sysclk_en: 1'b1, periph_all_en: 1'b1,
                       periph_subset_en: 1'b1, osc_en: 1'b1};
      service_q   <= 1'b0;
      resume_q    <= 1'b0;
      osrc_q      <= SRC_NONE;
      nmi_seen_q  <= 1'b0;
    end else begin
      state_q     <= state_d;
      mode_q      <= mode_d;
      ctrl_q      <= ctrl_d;
      rdata_q     <= rdata_d;
      enter_cnt_q <= enter_cnt_d;
      warm_cnt_q  <= warm_cnt_d;
      pend_nmi_q  <= pend_nmi_d;
      pend_i0_q   <= pend_i0_d;
      serve_q     <= serve_d;
      src_q       <= src_d;
      clk_q       <= clk_d;
      gate_q      <= gate_d;
      service_q   <= service_d;
      resume_q    <= resume_d;
      osrc_q      <= osrc_d;
      nmi_seen_q  <= nmi_seen_d;
    end
  end

  // ram is never cleared by this block, so it stays valid through reset
  logic ram_retain_q;
  always_ff @(posedge i_clock) begin
    ram_retain_q <= 1'b1;
  end

  assign o_rdata       = rdata_q;
  assign o_gate        = gate_q;
  assign o_clk_out     = clk_q;
  assign o_service     = service_q;
  assign o_service_src = osrc_q;
  assign o_resume      = resume_q;
  assign o_ram_retain  = ram_retain_q;

endmodule

/* File: halt_standby_pkg.sv */
// constants, states and carriers for the halt standby controller
// assumes a single 25 MHz system clock and a plain register port
package halt_standby_pkg;

  localparam int unsigned CLOCK_HZ          = 25_000_000;
  localparam int unsigned ENTRY_OSC_CLOCKS  = 3;
  localparam int unsigned RESET_STOP_MIN_MS = 3;
  localparam int unsigned RESET_STOP_MIN_CYC =
    (RESET_STOP_MIN_MS * CLOCK_HZ + 999) / 1000;

  localparam logic [2:0] NMI_FIXED_LEVEL = 3'h7;

  localparam logic [1:0] MODE_RUN   = 2'h0;
  localparam logic [1:0] MODE_STOP  = 2'h1;
  localparam logic [1:0] MODE_IDLE_OSCILLATOR_MODE = 2'h2;
  localparam logic [1:0] MODE_IDLE_PERIPHERAL_MODE = 2'h3;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_WARM_LSB = 2;
  localparam int unsigned STAT_PEND_NMI = 8;
  localparam int unsigned STAT_PEND_I0  = 9;
  localparam logic [3:0] CTRL_RESET     = 4'h0;

  typedef enum logic [7:0] {
    ST_ACTIVE   = 8'h01,
    ST_ENTER    = 8'h02,
    ST_H_RUN    = 8'h04,
    ST_H_PERIPH = 8'h08,
    ST_H_OSC    = 8'h10,
    ST_H_STOP   = 8'h20,
    ST_WARMUP   = 8'h40,
    ST_WAKE     = 8'h80
  } state_t;

  typedef enum logic [1:0] {
    SRC_NONE  = 2'h0,
    SRC_NMI   = 2'h1,
    SRC_PRIMARY_EXTERNAL_IRQ  = 2'h2,
    SRC_OTHER = 2'h3
  } src_t;

  // maskable request from the interrupt controller
  typedef struct packed {
    logic       valid;
    logic [2:0] level;
    logic       wd_or_conv;
  } irq_req_t;

  // clock and gating enables
  typedef struct packed {
    logic cpu_run;
    logic sysclk_en;
    logic periph_all_en;
    logic periph_subset_en;
    logic osc_en;
  } gate_t;

endpackage

/* File: halt_standby_control_sva.sv */
// checker for the halt standby controller
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ns
module halt_standby_control_sva
  import halt_standby_pkg::*;
#(
  parameter int unsigned WARMUP_BASE_CYC = 256
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_halt_exec,
  input gate_t     o_gate,
  input wire logic o_clk_out,
  input wire logic o_service,
  input src_t      o_service_src,
  input wire logic o_resume,
  input wire logic o_ram_retain
);
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_wake;
    o_service || o_resume;
  endsequence
  sequence s_warm;
    !o_gate.cpu_run [*3];
  endsequence

  property p_stop_off;
    !o_gate.osc_en |-> o_gate == 5'h00;
  endproperty
  property p_clk_high;
    !o_gate.sysclk_en |-> o_clk_out;
  endproperty
  property p_osc_only;
    o_gate.osc_en && !o_gate.sysclk_en && !o_gate.periph_subset_en
      |-> !o_gate.periph_all_en && !o_gate.cpu_run;
  endproperty
  property p_run_clk;
    o_gate.periph_all_en |-> o_gate.sysclk_en && o_gate.osc_en;
  endproperty
  property p_halt_cause;
    $fell(o_gate.cpu_run) |-> $past(i_halt_exec);
  endproperty
  property p_warmup;
    $rose(o_gate.osc_en) |-> s_warm;
  endproperty
  property p_resume_src;
    o_resume |-> o_service_src == SRC_PRIMARY_EXTERNAL_IRQ;
  endproperty
  property p_nmi_served;
    s_wake ##0 (o_service_src == SRC_NMI) |-> o_service;
  endproperty
  property p_wake_run;
    s_wake |-> o_gate.cpu_run && !(o_service && o_resume) && o_service_src != SRC_NONE;
  endproperty
  property p_ram;
    o_ram_retain;
  endproperty
  property p_reset_rel;
    $rose(i_rst_n) |-> o_gate == 5'h1F && o_clk_out;
  endproperty

  a_stop_off: assert property (p_stop_off) else $error("stop gates not all off");
  a_clk_high: assert property (p_clk_high) else $error("clock out not high");
  a_osc_only: assert property (p_osc_only) else $error("osc mode gating wrong");
  a_run_clk: assert property (p_run_clk) else $error("peripherals without clock");
  a_halt_cause: assert property (p_halt_cause) else $error("cpu stopped without halt");
  a_warmup: assert property (p_warmup) else $error("warm-up too short");
  a_resume_src: assert property (p_resume_src) else $error("resume from wrong source");
  a_nmi_served: assert property (p_nmi_served) else $error("nmi wake not serviced");
  a_wake_run: assert property (p_wake_run) else $error("wake pulse malformed");
  a_ram: assert property (p_ram) else $error("ram retain low");
  a_reset_rel: assert property (p_reset_rel) else $error("reset left a halt");
endmodule

bind halt_standby_control halt_standby_control_sva #(.WARMUP_BASE_CYC(WARMUP_BASE_CYC)) u_sva (
  .i_clock, .i_rst_n, .i_halt_exec, .o_gate, .o_clk_out, .o_service, .o_service_src,
  .o_resume, .o_ram_retain);

/* File: halt_irq_partner.sv */
// far-side model: interrupt controller and external interrupt pins
// assumes the bench calls req and feeds back the wake pulses
`timescale 1ns/1ns
module halt_irq_partner
  import halt_standby_pkg::*;
(
  input  wire logic  i_clock,
  input  wire logic  i_wake,
  output irq_req_t   o_irq,
  output logic       o_nmi_pin,
  output logic       o_primary_external_irq_pin,
  output logic [2:0] o_primary_external_irq_level
);
  initial begin
    o_irq = '0;
    o_nmi_pin = 1'b0;
    o_primary_external_irq_pin = 1'b0;
    o_primary_external_irq_level = 3'h0;
  end
  // kind 0 maskable, 1 nonmaskable pin, 2 primary pin
  task req(input int k, input logic [2:0] lv, input logic wd, input int n);
    int c;
    c = 0;
    @(posedge i_clock);
    if (k == 0) o_irq <= '{1'b1, lv, wd};
    o_nmi_pin <= (k == 1);
    o_primary_external_irq_pin <= (k == 2);
    o_primary_external_irq_level <= lv;
    do begin // pin requests held until a wake pulse or n clocks; primary level is left in place
      @(posedge i_clock);
      c++;
    end while (i_wake !== 1'b1 && c < n);
    o_irq <= '0;
    o_nmi_pin <= 1'b0;
    o_primary_external_irq_pin <= 1'b0;
  endtask
endmodule

/* File: halt_standby_control_tb.sv */
// testbench for the halt standby controller
// assumes the partner model and the bound checker
`timescale 1ns/1ns
module halt_standby_control_tb;
  import halt_standby_pkg::*;
  localparam int unsigned WB = 4;
  logic        i_clock, i_rst_n, i_halt_exec, i_wr, i_rd;
  logic [2:0]  i_mask_level, i_primary_external_irq_level;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic        i_nmi_pin, i_primary_external_irq_pin, o_clk_out, o_service, o_resume, o_ram_retain;
  irq_req_t    i_irq;
  gate_t       o_gate;
  src_t        o_service_src, src_q;
  int          err_count, num_checks, svc_n, res_n;
  wire logic   wake = o_service | o_resume;

  halt_standby_control #(.WARMUP_BASE_CYC(WB)) DUT (.i_clock, .i_rst_n, .i_halt_exec,
    .i_mask_level, .i_irq, .i_nmi_pin, .i_primary_external_irq_pin, .i_primary_external_irq_level, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_gate, .o_clk_out, .o_service, .o_service_src, .o_resume,
    .o_ram_retain);
  halt_irq_partner u_far (.i_clock, .i_wake(wake), .o_irq(i_irq), .o_nmi_pin(i_nmi_pin),
    .o_primary_external_irq_pin(i_primary_external_irq_pin), .o_primary_external_irq_level(i_primary_external_irq_level));

  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  always @(posedge i_clock) if (wake === 1'b1) begin
    svc_n += o_service;
    res_n += o_resume;
    src_q = o_service_src;
  end

  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %0h exp %0h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task halt(input logic [1:0] m);
    wr(ADDR_CTRL, {28'h0, 2'h1, m});
    #1 chk(o_gate, 5'h1F);
    @(posedge i_clock);
    i_halt_exec <= 1'b1;
    @(posedge i_clock);
    i_halt_exec <= 1'b0;
    repeat (6) @(posedge i_clock);
  endtask
  // one request from the far side, then judge the wake outcome
  task run(input int k, input logic [2:0] lv, input logic wd, input int n,
           input logic w, input logic s, input src_t src, input int lo);
    int a, b, c;
    a = svc_n + res_n;
    b = svc_n;
    c = 0;
    fork
      u_far.req(k, lv, wd, n);
      while (svc_n + res_n == a && c < n + 4) begin
        @(posedge i_clock);
        #1 c++;
      end
    join
    chk(svc_n + res_n - a, w);
    if (w && svc_n + res_n == a) stop_test;
    if (w) begin
      chk(svc_n - b, s);
      chk(src_q, src);
      chk(c >= lo, 1);
    end
    repeat (3) @(posedge i_clock);
  endtask

  task t_reset;
    logic [31:0] d;
    chk(o_gate, 5'h1F);
    chk(o_clk_out, 1);
    chk(o_ram_retain, 1);
    rd(ADDR_STATUS, d);
    chk(d[7:0], ST_ACTIVE);
    rd(8'hFC, d);
    chk(d, 0);
    $display("test reset done");
  endtask
  task t_modes;
    logic [31:0] d;
    logic [1:0]  m [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
    logic [4:0]  ge [4] = '{5'h0F, 5'h03, 5'h01, 5'h00};
    logic [4:0]  gm [4] = '{5'h1F, 5'h17, 5'h1F, 5'h1F};
    logic [7:0]  st [4] = '{ST_H_RUN, ST_H_PERIPH, ST_H_OSC, ST_H_STOP};
    i_mask_level <= 3'h7;
    for (int i = 0; i < 4; i++) begin
      halt(m[i]);
      chk(o_gate & gm[i], ge[i]);
      chk(o_clk_out | o_gate.sysclk_en, 1);
      rd(ADDR_STATUS, d);
      chk(d[7:0], st[i]);
      run(1, 3'h0, 1'b0, 400, 1, 1, SRC_NMI, (i == 3) ? WB * 4 : 0);
      rd(ADDR_STATUS, d);
      chk(d[7:0], ST_ACTIVE);
    end
    $display("test modes done");
  endtask
  task t_mask;
    i_mask_level <= 3'h4;
    halt(2'h0);
    run(0, 3'h3, 1'b0, 12, 0, 0, SRC_NONE, 0);
    run(0, 3'h4, 1'b1, 60, 1, 1, SRC_OTHER, 0);
    halt(2'h3);
    run(0, 3'h5, 1'b1, 12, 0, 0, SRC_NONE, 0);
    run(0, 3'h5, 1'b0, 60, 1, 1, SRC_OTHER, 0);
    halt(2'h1);
    run(2, 3'h5, 1'b0, 200, 1, 1, SRC_PRIMARY_EXTERNAL_IRQ, WB * 4);
    halt(2'h2);
    run(0, 3'h7, 1'b0, 12, 0, 0, SRC_NONE, 0);
    run(2, 3'h2, 1'b0, 60, 1, 0, SRC_PRIMARY_EXTERNAL_IRQ, 0);
    $display("test mask done");
  endtask
  // nmi raised during the entry cycles is held, then served ahead of primary
  task t_pend;
    int a;
    i_mask_level <= 3'h0;
    wr(ADDR_CTRL, {28'h0, 2'h1, MODE_IDLE_OSCILLATOR_MODE});
    a = svc_n;
    fork
      u_far.req(1, 3'h0, 1'b0, 10);
      begin
        @(posedge i_clock);
        i_halt_exec <= 1'b1;
        @(posedge i_clock);
        i_halt_exec <= 1'b0;
      end
    join
    repeat (8) @(posedge i_clock);
    chk(svc_n - a, 0);
    run(2, 3'h3, 1'b0, 60, 1, 1, SRC_NMI, 0);
    chk(svc_n - a, 2);
    $display("test pend done");
  endtask
  task t_rst_stop;
    halt(2'h1);
    i_rst_n <= 1'b0;
    repeat (RESET_STOP_MIN_CYC) @(posedge i_clock);
    i_rst_n <= 1'b1;
    #1 t_reset;
    $display("test stop reset done");
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_halt_exec = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_mask_level = 3'h0;
    src_q = SRC_NONE;
    err_count = 0;
    num_checks = 0;
    svc_n = 0;
    res_n = 0;
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    #1 t_reset;
    t_modes;
    t_mask;
    t_pend;
    t_rst_stop;
    stop_test;
  end
endmodule
